//--- src/sqlf_defs.svh
`ifndef SQLF_DEFS_SVH
`define SQLF_DEFS_SVH

`define SQLF_ADDR_W 8
`define SQLF_DATA_W 32
`define SQLF_LIM_W 12
`define SQLF_NUM_CHAN 16
`define SQLF_CHAN_W 4
`define SQLF_EVT_W 3

`define SQLF_OFS_LIMIT 8'h3C
`define SQLF_OFS_FLAGS 8'h40
`define SQLF_OFS_EVT_STATUS 8'h44
`define SQLF_OFS_EVT_MASK 8'h48
`define SQLF_OFS_CHAN_EN 8'h4C

`define SQLF_LIMIT_RST 24'hFFF000
`define SQLF_UPPER_HI 23
`define SQLF_UPPER_LO 12
`define SQLF_LOWER_HI 11
`define SQLF_LOWER_LO 0

`define SQLF_BIT_UPPER 0
`define SQLF_BIT_LOWER 1
`define SQLF_BIT_RDERR 2

`endif

//--- src/sqlf_pkg.sv
`include "sqlf_defs.svh"

package sqlf_pkg;

  typedef struct packed {
    logic [`SQLF_LIM_W-1:0] upperLimitValue;
    logic [`SQLF_LIM_W-1:0] lowerLimitValue;
    logic [`SQLF_NUM_CHAN-1:0] channelLimitCheckEnable;
    logic upperLimitFlag;
    logic lowerLimitFlag;
    logic readErr;
    logic upperIrq;
    logic lowerIrq;
    logic readErrIrq;
    logic [`SQLF_EVT_W-1:0] evtStatus;
    logic [`SQLF_EVT_W-1:0] evtMask;
    logic irq;
    logic [`SQLF_DATA_W-1:0] rdData;
  } sqlf_state_type;

endpackage : sqlf_pkg

//--- src/sqlf_limit_cmp.sv
`timescale 1ns/10ps
`default_nettype none
`include "sqlf_defs.svh"

module sqlf_limit_cmp
  import sqlf_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input wire logic [SAMPLE_W-1:0] sampleData,
  input wire logic [`SQLF_LIM_W-1:0] upperLimitValue,
  input wire logic [`SQLF_LIM_W-1:0] lowerLimitValue,
  output logic hitUpper,
  output logic hitLower
);

  logic [`SQLF_LIM_W-1:0] sampleTop;

  // unsigned compare on the top bits of the result
  assign sampleTop = sampleData[SAMPLE_W-1 -: `SQLF_LIM_W];
  assign hitUpper = (sampleTop >= upperLimitValue);
  assign hitLower = (sampleTop <= lowerLimitValue);

endmodule : sqlf_limit_cmp

`default_nettype wire

//--- src/sqlf_flags.sv
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "sqlf_defs.svh"

//Function
//- set upper flag on enabled result >= upper
//- set lower flag on enabled result <= lower
//- limit flags hold until queue emptied
//- limit interrupts track their flags exactly
//- read-error status is one bit
//- limit flags read-only, reset to zero
//- read error on refused read, cleared on granted read or empty
//- limit register upper/lower fields, reset FFF000
module sqlf_flags
  import sqlf_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [`SQLF_ADDR_W-1:0] regAddr,
  input wire logic [`SQLF_DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [`SQLF_DATA_W-1:0] regRdData,
  input wire logic sampleStore,
  input wire logic [SAMPLE_W-1:0] sampleData,
  input wire logic [`SQLF_CHAN_W-1:0] sampleChan,
  input wire logic queueEmptied,
  input wire logic readReq,
  output logic upperLimitFlag,
  output logic lowerLimitFlag,
  output logic readErr,
  output logic upperIrq,
  output logic lowerIrq,
  output logic readErrIrq,
  output logic irq
);

  sqlf_state_type st_r;
  sqlf_state_type st_nxt;
  logic hitUpper;
  logic hitLower;
  logic checkEn;
  logic setUpper;
  logic setLower;
  logic setRdErr;
  logic [`SQLF_EVT_W-1:0] events;
  logic [`SQLF_EVT_W-1:0] clrMask;
  localparam logic [`SQLF_UPPER_HI:0] LIMIT_RST = `SQLF_LIMIT_RST;

  function automatic logic hit(input logic [`SQLF_ADDR_W-1:0] a, input logic [`SQLF_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // reset image: flags and events clear, limits at their reset values
  function automatic sqlf_state_type resetState();
    sqlf_state_type s;
    s = '0;
    s.upperLimitValue = LIMIT_RST[`SQLF_UPPER_HI:`SQLF_UPPER_LO];
    s.lowerLimitValue = LIMIT_RST[`SQLF_LOWER_HI:`SQLF_LOWER_LO];
    return s;
  endfunction : resetState

  sqlf_limit_cmp #(
    .SAMPLE_W(SAMPLE_W)
  ) i_sqlf_limit_cmp (
    .sampleData(sampleData),
    .upperLimitValue(st_r.upperLimitValue),
    .lowerLimitValue(st_r.lowerLimitValue),
    .hitUpper(hitUpper),
    .hitLower(hitLower)
  );

  always_comb begin
    st_nxt = st_r;
    checkEn = st_r.channelLimitCheckEnable[sampleChan];
    setUpper = sampleStore & checkEn & hitUpper;
    setLower = sampleStore & checkEn & hitLower;
    setRdErr = readReq & sampleStore;
    events = '0;
    events[`SQLF_BIT_UPPER] = setUpper & ~st_r.upperLimitFlag;
    events[`SQLF_BIT_LOWER] = setLower & ~st_r.lowerLimitFlag;
    events[`SQLF_BIT_RDERR] = setRdErr & ~st_r.readErr;
    clrMask = '0;

    // flags hold until the queue empties; a new hit wins
    if (setUpper) begin
      st_nxt.upperLimitFlag = 1'h1;
    end else if (queueEmptied) begin
      st_nxt.upperLimitFlag = 1'h0;
    end
    if (setLower) begin
      st_nxt.lowerLimitFlag = 1'h1;
    end else if (queueEmptied) begin
      st_nxt.lowerLimitFlag = 1'h0;
    end
    // refused read sets, granted read or empty clears
    if (setRdErr) begin
      st_nxt.readErr = 1'h1;
    end else if (readReq | queueEmptied) begin
      st_nxt.readErr = 1'h0;
    end
    // interrupts share the next value of their flag
    st_nxt.upperIrq = st_nxt.upperLimitFlag;
    st_nxt.lowerIrq = st_nxt.lowerLimitFlag;
    st_nxt.readErrIrq = st_nxt.readErr;

    if (regWrStb) begin
      if (hit(regAddr, `SQLF_OFS_LIMIT)) begin
        st_nxt.upperLimitValue = regWrData[`SQLF_UPPER_HI:`SQLF_UPPER_LO];
        st_nxt.lowerLimitValue = regWrData[`SQLF_LOWER_HI:`SQLF_LOWER_LO];
      end
      if (hit(regAddr, `SQLF_OFS_EVT_STATUS)) begin
        clrMask = regWrData[`SQLF_EVT_W-1:0];
      end
      if (hit(regAddr, `SQLF_OFS_EVT_MASK)) begin
        st_nxt.evtMask = regWrData[`SQLF_EVT_W-1:0];
      end
      if (hit(regAddr, `SQLF_OFS_CHAN_EN)) begin
        st_nxt.channelLimitCheckEnable = regWrData[`SQLF_NUM_CHAN-1:0];
      end
    end
    // sticky events, a set wins over a write-one clear
    st_nxt.evtStatus = (st_r.evtStatus & ~clrMask) | events;
    st_nxt.irq = |(st_nxt.evtStatus & st_nxt.evtMask);

    // read data valid only in the cycle after the strobe
    st_nxt.rdData = '0;
    if (regRdStb) begin
      if (hit(regAddr, `SQLF_OFS_LIMIT)) begin
        st_nxt.rdData[`SQLF_UPPER_HI:`SQLF_UPPER_LO] = st_r.upperLimitValue;
        st_nxt.rdData[`SQLF_LOWER_HI:`SQLF_LOWER_LO] = st_r.lowerLimitValue;
      end
      if (hit(regAddr, `SQLF_OFS_FLAGS)) begin
        // writes to this word are ignored single-bit error
        st_nxt.rdData[`SQLF_BIT_UPPER] = st_r.upperLimitFlag;
        st_nxt.rdData[`SQLF_BIT_LOWER] = st_r.lowerLimitFlag;
        st_nxt.rdData[`SQLF_BIT_RDERR] = st_r.readErr;
      end
      if (hit(regAddr, `SQLF_OFS_EVT_STATUS)) begin
        st_nxt.rdData[`SQLF_EVT_W-1:0] = st_r.evtStatus;
      end
      if (hit(regAddr, `SQLF_OFS_EVT_MASK)) begin
        st_nxt.rdData[`SQLF_EVT_W-1:0] = st_r.evtMask;
      end
      if (hit(regAddr, `SQLF_OFS_CHAN_EN)) begin
        st_nxt.rdData[`SQLF_NUM_CHAN-1:0] = st_r.channelLimitCheckEnable;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= resetState();
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign upperLimitFlag = st_r.upperLimitFlag;
  assign lowerLimitFlag = st_r.lowerLimitFlag;
  assign readErr = st_r.readErr;
  assign upperIrq = st_r.upperIrq;
  assign lowerIrq = st_r.lowerIrq;
  assign readErrIrq = st_r.readErrIrq;
  assign irq = st_r.irq;

endmodule : sqlf_flags

`default_nettype wire

//--- verif/sqlf_flags_props.sv
`timescale 1ns/10ps
`default_nettype none
module sqlf_flags_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sampleStore,
  input wire logic queueEmptied,
  input wire logic readReq,
  input wire logic regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic upperLimitFlag,
  input wire logic lowerLimitFlag,
  input wire logic readErr,
  input wire logic upperIrq,
  input wire logic lowerIrq,
  input wire logic readErrIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_upper_irq_track: assert property (upperIrq == upperLimitFlag)
    else $error("upper irq differs from flag");
  a_lower_irq_track: assert property (lowerIrq == lowerLimitFlag)
    else $error("lower irq differs from flag");
  a_rderr_irq_track: assert property (readErrIrq == readErr)
    else $error("read error irq differs");
  a_rderr_set: assert property (readReq && sampleStore |=> readErr)
    else $error("refused read not flagged");
  a_rderr_clear: assert property (readReq && !sampleStore |=> !readErr)
    else $error("granted read left error");
  a_empty_clears: assert property (queueEmptied && !sampleStore && !readReq |=> !upperLimitFlag && !lowerLimitFlag && !readErr)
    else $error("flags survive empty");
  a_upper_hold: assert property (upperLimitFlag && !queueEmptied |=> upperLimitFlag)
    else $error("upper flag dropped");
  a_lower_hold: assert property (lowerLimitFlag && !queueEmptied |=> lowerLimitFlag)
    else $error("lower flag dropped");
  a_upper_cause: assert property ($rose(upperLimitFlag) |-> $past(sampleStore))
    else $error("upper flag without sample");
  a_lower_cause: assert property ($rose(lowerLimitFlag) |-> $past(sampleStore))
    else $error("lower flag without sample");
  a_rdata_idle: assert property (!regRdStb |=> regRdData == 32'h0)
    else $error("read data outside read slot");
endmodule : sqlf_flags_props
`default_nettype wire

//--- verif/sample_queue_limit_flags_test.sv
`timescale 1ns/10ps
`default_nettype none
module sample_queue_limit_flags_test;
  logic mclk, nrst, regWrStb, regRdStb, sampleStore, queueEmptied, readReq;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, outs;
  logic [15:0] sampleData;
  logic [3:0] sampleChan;
  logic upperLimitFlag, lowerLimitFlag, readErr, upperIrq, lowerIrq, readErrIrq, irq;
  int failCount = 0;
  int nChecks = 0;
  assign outs = {25'h0, irq, readErrIrq, readErr, lowerIrq, lowerLimitFlag, upperIrq, upperLimitFlag};
  sqlf_flags #(.SAMPLE_W(16)) i_sqlf_flags (.mclk, .nrst, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .sampleStore, .sampleData, .sampleChan, .queueEmptied, .readReq, .upperLimitFlag,
    .lowerLimitFlag, .readErr, .upperIrq, .lowerIrq, .readErrIrq, .irq);
  task automatic giveVerdict();
    $display("checks=%0d errors=%0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : giveVerdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkOuts(input logic [31:0] e);
    nChecks++;
    if (outs !== e) begin
      failCount++;
      $display("ERROR t=%0t outs=%h exp=%h", $time, outs, e);
    end
  endtask : chkOuts
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge mclk);
    regWrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge mclk);
    regRdStb <= 1'b0;
    @(negedge mclk);
    chk(regRdData, e);
  endtask : rd
  task automatic smp(input logic [3:0] c, input logic [15:0] d, input logic s, input logic r, input logic q);
    @(posedge mclk);
    sampleChan <= c;
    sampleData <= d;
    sampleStore <= s;
    readReq <= r;
    queueEmptied <= q;
    @(posedge mclk);
    sampleStore <= 1'b0;
    readReq <= 1'b0;
    queueEmptied <= 1'b0;
    @(negedge mclk);
  endtask : smp
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    failCount++;
    giveVerdict();
  end
  initial begin
    {nrst, regWrStb, regRdStb, sampleStore, queueEmptied, readReq} = 6'h0;
    {regAddr, regWrData, sampleData, sampleChan} = 60'h0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h3C, 32'h00FFF000);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'h7);
    rd(8'h40, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    wr(8'h4C, 32'h8);
    wr(8'h48, 32'h7);
    wr(8'h3C, 32'h00800100);
    rd(8'h3C, 32'h00800100);
    smp(4'h2, 16'hFFF0, 1'h1, 1'h0, 1'h0);
    chkOuts(32'h0);
    smp(4'h3, 16'h7FF0, 1'h1, 1'h0, 1'h0);
    smp(4'h3, 16'h1010, 1'h1, 1'h0, 1'h0);
    chkOuts(32'h0);
    smp(4'h3, 16'h8000, 1'h1, 1'h0, 1'h0);
    chkOuts(32'h43);
    smp(4'h3, 16'h1000, 1'h1, 1'h0, 1'h0);
    chkOuts(32'h4F);
    rd(8'h40, 32'h3);
    smp(4'h0, 16'h0, 1'h0, 1'h0, 1'h1);
    chkOuts(32'h40);
    smp(4'h0, 16'h0, 1'h1, 1'h1, 1'h0);
    chkOuts(32'h70);
    rd(8'h40, 32'h4);
    smp(4'h0, 16'h0, 1'h0, 1'h1, 1'h0);
    chkOuts(32'h40);
    rd(8'h44, 32'h7);
    wr(8'h44, 32'h7);
    rd(8'h44, 32'h0);
    chkOuts(32'h0);
    wr(8'h48, 32'h0);
    smp(4'h0, 16'h0, 1'h1, 1'h1, 1'h0);
    rd(8'h48, 32'h0);
    chkOuts(32'h30);
    wr(8'h48, 32'h4);
    rd(8'h48, 32'h4);
    chkOuts(32'h70);
    wr(8'h44, 32'h4);
    rd(8'h44, 32'h0);
    chkOuts(32'h30);
    // a hit in the same cycle as an empty keeps its flag, the error clears
    smp(4'h3, 16'h8000, 1'h1, 1'h0, 1'h1);
    chkOuts(32'h3);
    // reset in mid-run with a limit flag standing
    @(posedge mclk);
    nrst <= 1'h0;
    repeat (2) @(posedge mclk);
    nrst <= 1'h1;
    @(negedge mclk);
    chkOuts(32'h0);
    rd(8'h40, 32'h0);
    rd(8'h3C, 32'h00FFF000);
    rd(8'h4C, 32'h0);
    giveVerdict();
  end
endmodule : sample_queue_limit_flags_test
bind sqlf_flags sqlf_flags_props i_sqlf_flags_props (.mclk, .nrst, .sampleStore, .queueEmptied, .readReq,
  .regRdStb, .regRdData, .upperLimitFlag, .lowerLimitFlag, .readErr, .upperIrq, .lowerIrq, .readErrIrq);
`default_nettype wire
